// >>> dca_pkg.sv
// Purpose: shared constants, field layout and types of the multi-channel dma controller
// Assumes: classic wishbone slave, 16-bit registers in the low half of each 32-bit word
// Notes:   byte address of a register is its word index times four
//
// What this block does
// RULE1 - channels run independently but share the data and dma buses, so requests are arbitrated
// RULE2 - a software bit picks one of two priority schemes for collisions
// RULE3 - round robin: first collision goes to the lower numbered channel
// RULE4 - round robin: later collisions pass the grant upward by channel number
// RULE5 - fixed: lowest numbered requesting channel wins, unless it is the channel just serviced
// RULE6 - fixed: the channel just serviced is not granted again immediately
// RULE7 - fixed: a busy high channel waits behind the next lower pending channel
// RULE8 - software sets engine enable and picks the scheme before channel setup
// RULE9 - upper and lower address limits bound the data ram region for transfers
// RULE10 - software clears channel enable before changing a channel setup
// RULE11 - software writes source and destination pointers; base address for indirect mode
// RULE12 - count register counts triggers in single modes, words in repeated modes
// RULE13 - a per-channel size bit picks byte or word moves
// RULE14 - a two-bit transfer mode field picks one-shot, continuous or repeated variants
// RULE15 - two-bit source and destination addressing fields pick pointer behaviour
// RULE16 - software sets channel enable only after all channel fields are written
// RULE17 - software finally enables the trigger peripheral interrupt
// RULE18 - each channel is powered down on its own by a module disable bit
// RULE19 - one engine control, two address limits and a data buffer register are shared
// RULE20 - each channel has control, interrupt, source, destination and count registers
// RULE21 - a disabled channel raises no request and takes no part in arbitration
// RULE22 - with engine enable clear no channel is granted the bus
`default_nettype none
package dca_pkg;
  localparam int NCH = 4;
  localparam int CW  = 2;
  localparam int DW  = 16;
  // word index within a 32-byte block; block 0 is common, block n+1 is channel n
  localparam logic [2:0] IDX_ENG   = 3'h0;
  localparam logic [2:0] IDX_UPPER = 3'h1;
  localparam logic [2:0] IDX_LOWER = 3'h2;
  localparam logic [2:0] IDX_XBUF  = 3'h3;
  localparam logic [2:0] IDX_PMD   = 3'h4;
  localparam logic [2:0] IDX_CTL   = 3'h0;
  localparam logic [2:0] IDX_INT   = 3'h1;
  localparam logic [2:0] IDX_SRC   = 3'h2;
  localparam logic [2:0] IDX_DST   = 3'h3;
  localparam logic [2:0] IDX_CNT   = 3'h4;
  localparam logic [2:0] BLK_COMMON = 3'h0;
  // engine control fields
  localparam int ENG_EN   = 0;
  localparam int ENG_PRS  = 1;
  localparam int ENG_BUSY = 2;
  localparam logic PRS_FIXED = 1'b0;
  // channel control fields
  localparam int CTL_W      = 8;
  localparam int CTL_EN     = 0;
  localparam int CTL_SIZE   = 1;
  localparam int CTL_TRM_LO = 2;
  localparam int CTL_SAM_LO = 4;
  localparam int CTL_DAM_LO = 6;
  localparam int TRM_CONT   = 0;
  localparam int TRM_REPEAT = 1;
  localparam logic [1:0] AM_INC = 2'h0;
  localparam logic [1:0] AM_DEC = 2'h1;
  localparam logic [1:0] AM_FIX = 2'h2;
  localparam logic [1:0] AM_PIA = 2'h3;
  // channel interrupt flags
  localparam int INT_W     = 2;
  localparam int INT_DONE  = 0;
  localparam int INT_RANGE = 1;
  // reset values and step sizes
  localparam logic [CTL_W-1:0] CTL_RST   = 8'h00;
  localparam logic [DW-1:0]    UPPER_RST = 16'hffff;
  localparam logic [DW-1:0]    LOWER_RST = 16'h0000;
  localparam logic [DW-1:0]    STEP_BYTE = 16'h0001;
  localparam logic [DW-1:0]    STEP_WORD = 16'h0002;

  typedef enum logic [1:0] {E_IDLE, E_READ, E_WRITE, E_SETTLE} dca_eng_t;

  // byte-lane merge of a register write
  function automatic logic [DW-1:0] dca_merge(input logic [DW-1:0] old, input logic [DW-1:0] din,
                                              input logic [DW-1:0] mask);
    dca_merge = (old & ~mask) | (din & mask);
  endfunction : dca_merge
endpackage : dca_pkg
`default_nettype wire

// >>> dca_arbiter.sv
// Purpose: picks the channel that wins the shared buses
// Assumes: accept pulses in the cycle the engine takes the grant
// Notes:   remembers the last granted channel for both schemes
`timescale 1ns/10ps
`default_nettype none
module dca_arbiter (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic [dca_pkg::NCH-1:0] req,
  input  wire logic                    fixedMode,
  input  wire logic                    accept,
  output logic                         grantValid,
  output logic      [dca_pkg::CW-1:0]  grantCh
);
  logic [dca_pkg::CW-1:0]  lastCh;
  logic                    lastValid;
  logic [dca_pkg::CW-1:0]  rrCh;
  logic [dca_pkg::CW-1:0]  lowCh;
  logic [dca_pkg::CW-1:0]  fixCh;
  logic [dca_pkg::CW-1:0]  idx;
  logic [dca_pkg::NCH-1:0] others;

  // search orders for both schemes
  always_comb begin
    rrCh = '0;
    lowCh = '0;
    fixCh = '0;
    idx = '0;
    others = req;
    // RULE4 rotate upward from last
    for (int i = dca_pkg::NCH - 1; i >= 0; i--) begin
      idx = dca_pkg::CW'(lastCh + dca_pkg::CW'(1) + dca_pkg::CW'(i));
      if (req[idx]) begin
        rrCh = idx;
      end
    end
    // RULE6 skip channel just serviced
    if (lastValid && ((req & ~(dca_pkg::NCH'(1) << lastCh)) != '0)) begin
      others = req & ~(dca_pkg::NCH'(1) << lastCh);
    end
    // RULE5 lowest numbered wins
    for (int i = dca_pkg::NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        lowCh = dca_pkg::CW'(i);
      end
      if (others[i]) begin
        fixCh = dca_pkg::CW'(i);
      end
    end
  end

  // RULE2 scheme select
  assign grantValid = |req;
  assign grantCh    = fixedMode ? fixCh : rrCh;

  // RULE3 first grant starts below channel 0 wrap
  always_ff @(posedge clk) begin
    if (srst) begin
      lastCh    <= dca_pkg::CW'(dca_pkg::NCH - 1);
      lastValid <= 1'b0;
    end else if (accept) begin
      lastCh    <= grantCh;
      lastValid <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_grant_is_req: assert property (grantValid |-> req[grantCh]) else $error("grant without request"); // RULE1
  a_rr_first_low: assert property (!fixedMode && !lastValid && grantValid |-> grantCh == lowCh) // RULE3
    else $error("first round robin grant not lowest");
  a_rr_rotate_up: assert property (!fixedMode && lastValid && req[dca_pkg::CW'(lastCh + dca_pkg::CW'(1))] // RULE4
    |-> grantCh == dca_pkg::CW'(lastCh + dca_pkg::CW'(1))) else $error("round robin did not pass upward");
  a_fixed_lowest: assert property (fixedMode && grantValid && (!lastValid || lowCh != lastCh) // RULE5
    |-> grantCh == lowCh) else $error("fixed grant not lowest");
  a_fixed_no_regrant: assert property (accept && fixedMode ##1 fixedMode && lastValid // RULE6
    && (req & ~(dca_pkg::NCH'(1) << lastCh)) != '0 |-> grantCh != $past(grantCh)) else $error("immediate regrant");
endmodule : dca_arbiter
`default_nettype wire

// >>> dca_channel.sv
// Purpose: one channel: its registers, trigger latch and pointer stepping
// Assumes: step and abort are single-cycle pulses from the engine
// Notes:   power-down holds every register at reset and hides the channel
`timescale 1ns/10ps
`default_nettype none
module dca_channel (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   powerDown,
  input  wire logic                   trig,
  input  wire logic                   wrEn,
  input  wire logic [2:0]             wrIdx,
  input  wire logic [dca_pkg::DW-1:0] wrData,
  input  wire logic [dca_pkg::DW-1:0] wrMask,
  input  wire logic [2:0]             rdIdx,
  output logic      [dca_pkg::DW-1:0] rdData,
  input  wire logic                   step,
  input  wire logic                   abort,
  input  wire logic [dca_pkg::DW-1:0] upperLim,
  input  wire logic [dca_pkg::DW-1:0] lowerLim,
  output logic                        req,
  output logic                        rangeOk,
  output logic      [dca_pkg::DW-1:0] srcAddr,
  output logic      [dca_pkg::DW-1:0] dstAddr,
  output logic                        byteMode
);
  logic [dca_pkg::CTL_W-1:0] cfg;
  logic [dca_pkg::INT_W-1:0] flags;
  logic [dca_pkg::DW-1:0]    srcBase, dstBase, srcPtr, dstPtr, cntLoad, remain;
  logic                      pending;

  // pointer step per addressing mode
  function automatic logic [dca_pkg::DW-1:0] stepPtr(input logic [dca_pkg::DW-1:0] p, input logic [1:0] m,
                                                     input logic [dca_pkg::DW-1:0] sz);
    stepPtr = (m == dca_pkg::AM_INC) ? p + sz : (m == dca_pkg::AM_DEC) ? p - sz : p;
  endfunction : stepPtr

  // field decode
  wire       en    = cfg[dca_pkg::CTL_EN];
  wire [1:0] trm   = cfg[dca_pkg::CTL_TRM_LO +: 2];
  wire [1:0] sam   = cfg[dca_pkg::CTL_SAM_LO +: 2];
  wire [1:0] dam   = cfg[dca_pkg::CTL_DAM_LO +: 2];
  wire       last  = remain <= dca_pkg::STEP_BYTE;
  wire       endIt = step & last;
  wire       wCtl  = wrEn && wrIdx == dca_pkg::IDX_CTL;
  wire       wInt  = wrEn && wrIdx == dca_pkg::IDX_INT;
  wire       wSrc  = wrEn && wrIdx == dca_pkg::IDX_SRC;
  wire       wDst  = wrEn && wrIdx == dca_pkg::IDX_DST;
  wire       wCnt  = wrEn && wrIdx == dca_pkg::IDX_CNT;
  wire [dca_pkg::CTL_W-1:0] cfgNew = dca_pkg::CTL_W'(dca_pkg::dca_merge(dca_pkg::DW'(cfg), wrData, wrMask));
  wire       arm    = wCtl & cfgNew[dca_pkg::CTL_EN] & ~en;
  // RULE14 continuous modes reload at block end
  wire       reload = endIt & trm[dca_pkg::TRM_CONT];
  // RULE13 byte or word step
  wire [dca_pkg::DW-1:0] stepSz = cfg[dca_pkg::CTL_SIZE] ? dca_pkg::STEP_BYTE : dca_pkg::STEP_WORD;
  // RULE15 each pointer follows its own mode
  wire [dca_pkg::DW-1:0] next_srcPtr = (arm | reload) ? srcBase : step ? stepPtr(srcPtr, sam, stepSz) : srcPtr;
  wire [dca_pkg::DW-1:0] next_dstPtr = (arm | reload) ? dstBase : step ? stepPtr(dstPtr, dam, stepSz) : dstPtr;
  // RULE12 one count per element moved
  wire [dca_pkg::DW-1:0] next_remain = (arm | reload) ? cntLoad : step ? remain - dca_pkg::STEP_BYTE : remain;
  // RULE14 single modes drop the trigger after one element, repeated ones after the block
  wire       pendClr = abort | endIt | (step & ~trm[dca_pkg::TRM_REPEAT]);
  wire [dca_pkg::INT_W-1:0] flagSet = {abort, endIt};
  wire [dca_pkg::INT_W-1:0] flagClr = wInt ? wrData[dca_pkg::INT_W-1:0] & wrMask[dca_pkg::INT_W-1:0] : '0;

  // RULE18 power-down holds control at reset
  always_ff @(posedge clk) begin
    if (srst || powerDown) begin
      cfg <= dca_pkg::CTL_RST;
    end else if (wCtl) begin
      cfg <= cfgNew;
    end else if (abort || (endIt && !trm[dca_pkg::TRM_CONT])) begin
      cfg[dca_pkg::CTL_EN] <= 1'b0;
    end
  end

  // base, working pointers and counters
  always_ff @(posedge clk) begin
    if (srst || powerDown) begin
      {srcBase, dstBase, srcPtr, dstPtr, cntLoad, remain} <= '0;
    end else begin
      srcBase <= wSrc ? dca_pkg::dca_merge(srcBase, wrData, wrMask) : srcBase;
      dstBase <= wDst ? dca_pkg::dca_merge(dstBase, wrData, wrMask) : dstBase;
      cntLoad <= wCnt ? dca_pkg::dca_merge(cntLoad, wrData, wrMask) : cntLoad;
      srcPtr  <= wSrc ? dca_pkg::dca_merge(srcBase, wrData, wrMask) : next_srcPtr;
      dstPtr  <= wDst ? dca_pkg::dca_merge(dstBase, wrData, wrMask) : next_dstPtr;
      remain  <= wCnt ? dca_pkg::dca_merge(cntLoad, wrData, wrMask) : next_remain;
    end
  end

  // trigger latch and sticky flags, a new event beats a clear
  always_ff @(posedge clk) begin
    if (srst || powerDown) begin
      pending <= 1'b0;
      flags   <= '0;
    end else begin
      pending <= (en & trig) | (pending & ~pendClr & ~arm);
      flags   <= (flags & ~flagClr) | flagSet;
    end
  end

  // RULE21 only an enabled channel requests
  assign req = en & pending & ~powerDown;
  // RULE9 ram-side pointers must sit inside the limits
  assign rangeOk = (sam == dca_pkg::AM_PIA || (srcPtr >= lowerLim && srcPtr <= upperLim)) &&
                   (dam == dca_pkg::AM_PIA || (dstPtr >= lowerLim && dstPtr <= upperLim));
  assign srcAddr  = srcPtr;
  assign dstAddr  = dstPtr;
  assign byteMode = cfg[dca_pkg::CTL_SIZE];
  // RULE20 per-channel register read
  assign rdData = powerDown ? '0 :
                  rdIdx == dca_pkg::IDX_CTL ? dca_pkg::DW'(cfg) :
                  rdIdx == dca_pkg::IDX_INT ? dca_pkg::DW'(flags) :
                  rdIdx == dca_pkg::IDX_SRC ? srcPtr :
                  rdIdx == dca_pkg::IDX_DST ? dstPtr :
                  rdIdx == dca_pkg::IDX_CNT ? remain : '0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_pd_channel_quiet: assert property (powerDown |=> !req && cfg == dca_pkg::CTL_RST) // RULE18
    else $error("powered-down channel still active");
  a_count_decrements: assert property (step && !last && !wrEn |=> remain == $past(remain) - dca_pkg::STEP_BYTE) // RULE12
    else $error("count did not step");
  a_disabled_no_req: assert property (!en && !(wCtl && cfgNew[dca_pkg::CTL_EN]) |=> !req) // RULE21
    else $error("disabled channel requests");
endmodule : dca_channel
`default_nettype wire

// >>> dca_top.sv
// Purpose: multi-channel dma controller with wishbone register access
// Assumes: memory port request held until a one-cycle memAck
// Notes:   one element per grant; read from source then write to destination
`timescale 1ns/10ps
`default_nettype none
module dca_top (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    cyc_i,
  input  wire logic                    stb_i,
  input  wire logic                    we_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  output logic                         ack_o,
  input  wire logic [dca_pkg::NCH-1:0] trig,
  output logic                         memReq,
  output logic                         memWe,
  output logic                         memByte,
  output logic      [dca_pkg::DW-1:0]  memAddr,
  output logic      [dca_pkg::DW-1:0]  memWdata,
  input  wire logic                    memAck,
  input  wire logic [dca_pkg::DW-1:0]  memRdata
);
  // shared registers
  logic                     engEn;
  logic                     priority_scheme_select;
  logic [dca_pkg::DW-1:0]   upperLim;
  logic [dca_pkg::DW-1:0]   lowerLim;
  logic [dca_pkg::DW-1:0]   xferBuf;
  logic [dca_pkg::NCH-1:0]  module_power_disable;
  // engine state
  dca_pkg::dca_eng_t        state;
  logic [dca_pkg::CW-1:0]   curCh;
  logic                     stepPulse;
  logic                     abortPulse;
  // per-channel views
  logic [dca_pkg::DW-1:0]   chRd [dca_pkg::NCH];
  logic [dca_pkg::DW-1:0]   chSrc [dca_pkg::NCH];
  logic [dca_pkg::DW-1:0]   chDst [dca_pkg::NCH];
  logic [dca_pkg::NCH-1:0]  chReq;
  logic [dca_pkg::NCH-1:0]  chOk;
  logic [dca_pkg::NCH-1:0]  chByte;
  logic                     grantValid;
  logic [dca_pkg::CW-1:0]   grantCh;

  // bus decode
  wire        wbHit     = cyc_i & stb_i & ~ack_o;
  wire        wbWr      = wbHit & we_i;
  wire [2:0]  blk       = adr_i[7:5];
  wire [2:0]  regIdx    = adr_i[4:2];
  wire [dca_pkg::CW-1:0] blkCh = dca_pkg::CW'(blk - 3'h1);
  wire        commonSel = blk == dca_pkg::BLK_COMMON;
  wire        chanSel   = blk != dca_pkg::BLK_COMMON && blk <= 3'(dca_pkg::NCH);
  wire [dca_pkg::DW-1:0] wrMask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire        busy      = state != dca_pkg::E_IDLE;

  // RULE19 shared register read
  wire [dca_pkg::DW-1:0] engRd = dca_pkg::DW'({busy, priority_scheme_select, engEn});
  wire [dca_pkg::DW-1:0] commonRd =
    regIdx == dca_pkg::IDX_ENG   ? engRd :
    regIdx == dca_pkg::IDX_UPPER ? upperLim :
    regIdx == dca_pkg::IDX_LOWER ? lowerLim :
    regIdx == dca_pkg::IDX_XBUF  ? xferBuf :
    regIdx == dca_pkg::IDX_PMD   ? dca_pkg::DW'(module_power_disable) : '0;
  wire [dca_pkg::DW-1:0] rdMux = commonSel ? commonRd : chanSel ? chRd[blkCh] : '0;

  // wishbone answer one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= wbHit;
      dat_o <= wbHit ? {16'h0000, rdMux} : dat_o;
    end
  end

  // shared control and limit registers
  wire [dca_pkg::DW-1:0] engNew = dca_pkg::dca_merge(engRd, dat_i[15:0], wrMask);
  wire [dca_pkg::DW-1:0] pmdNew = dca_pkg::dca_merge(dca_pkg::DW'(module_power_disable), dat_i[15:0], wrMask);
  always_ff @(posedge clk) begin
    if (srst) begin
      engEn    <= 1'b0;
      priority_scheme_select   <= dca_pkg::PRS_FIXED;
      upperLim <= dca_pkg::UPPER_RST;
      lowerLim <= dca_pkg::LOWER_RST;
      module_power_disable      <= '0;
    end else if (wbWr && commonSel) begin
      if (regIdx == dca_pkg::IDX_ENG) begin
        engEn  <= engNew[dca_pkg::ENG_EN];
        priority_scheme_select <= engNew[dca_pkg::ENG_PRS];
      end
      if (regIdx == dca_pkg::IDX_UPPER) begin
        upperLim <= dca_pkg::dca_merge(upperLim, dat_i[15:0], wrMask);
      end
      if (regIdx == dca_pkg::IDX_LOWER) begin
        lowerLim <= dca_pkg::dca_merge(lowerLim, dat_i[15:0], wrMask);
      end
      if (regIdx == dca_pkg::IDX_PMD) begin
        module_power_disable <= dca_pkg::NCH'(pmdNew);
      end
    end
  end

  // RULE1 independent channels
  for (genvar c = 0; c < dca_pkg::NCH; c++) begin : g_ch
    dca_channel u_ch (
      .clk       (clk),
      .srst      (srst),
      .powerDown (module_power_disable[c]),
      .trig      (trig[c]),
      .wrEn      (wbWr && chanSel && blkCh == dca_pkg::CW'(c)),
      .wrIdx     (regIdx),
      .wrData    (dat_i[15:0]),
      .wrMask    (wrMask),
      .rdIdx     (regIdx),
      .rdData    (chRd[c]),
      .step      (stepPulse && curCh == dca_pkg::CW'(c)),
      .abort     (abortPulse && curCh == dca_pkg::CW'(c)),
      .upperLim  (upperLim),
      .lowerLim  (lowerLim),
      .req       (chReq[c]),
      .rangeOk   (chOk[c]),
      .srcAddr   (chSrc[c]),
      .dstAddr   (chDst[c]),
      .byteMode  (chByte[c])
    );
  end

  // RULE22 grants only while the engine is enabled
  wire accept = state == dca_pkg::E_IDLE && engEn && grantValid;
  wire [dca_pkg::DW-1:0] rdVal = chByte[curCh] ? {8'h00, memRdata[7:0]} : memRdata;

  // RULE2 scheme bit steers the arbiter
  dca_arbiter u_arb (
    .clk        (clk),
    .srst       (srst),
    .req        (chReq),
    .fixedMode  (priority_scheme_select == dca_pkg::PRS_FIXED),
    .accept     (accept),
    .grantValid (grantValid),
    .grantCh    (grantCh)
  );

  // engine sequence: grant, read source, write destination, settle
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= dca_pkg::E_IDLE;
      curCh <= '0;
    end else begin
      unique case (state)
        dca_pkg::E_IDLE: begin
          if (accept) begin
            curCh <= grantCh;
            state <= chOk[grantCh] ? dca_pkg::E_READ : dca_pkg::E_SETTLE;
          end
        end
        dca_pkg::E_READ: begin
          if (memAck) begin
            state <= dca_pkg::E_WRITE;
          end
        end
        dca_pkg::E_WRITE: begin
          if (memAck) begin
            state <= dca_pkg::E_SETTLE;
          end
        end
        dca_pkg::E_SETTLE: begin
          state <= dca_pkg::E_IDLE;
        end
      endcase
    end
  end

  // memory port, held until acknowledged
  always_ff @(posedge clk) begin
    if (srst) begin
      {memReq, memWe, memByte} <= '0;
      memAddr  <= '0;
      memWdata <= '0;
    end else if (accept && chOk[grantCh]) begin
      // RULE13 size bit travels with the access
      {memReq, memWe, memByte} <= {1'b1, 1'b0, chByte[grantCh]};
      memAddr <= chSrc[grantCh];
    end else if (state == dca_pkg::E_READ && memAck) begin
      memWe    <= 1'b1;
      memAddr  <= chDst[curCh];
      memWdata <= rdVal;
    end else if (state == dca_pkg::E_WRITE && memAck) begin
      {memReq, memWe} <= 2'b00;
    end
  end

  // RULE9 out-of-window transfer is aborted; read data is also copied into the buffer
  always_ff @(posedge clk) begin
    if (srst) begin
      xferBuf    <= '0;
      stepPulse  <= 1'b0;
      abortPulse <= 1'b0;
    end else begin
      xferBuf    <= (state == dca_pkg::E_READ && memAck) ? rdVal : xferBuf;
      stepPulse  <= state == dca_pkg::E_WRITE && memAck;
      abortPulse <= accept && !chOk[grantCh];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_read_done;
    memReq && !memWe && memAck;
  endsequence
  sequence s_write_issued;
    memReq && memWe && memAddr == chDst[curCh];
  endsequence

  a_engine_gate: assert property ($rose(memReq) |-> $past(engEn)) else $error("grant while engine off"); // RULE22
  a_read_to_write: assert property (s_read_done |=> s_write_issued) else $error("write did not follow read"); // RULE1
  a_step_after_write: assert property (memReq && memWe && memAck |=> stepPulse ##1 !stepPulse) // RULE12
    else $error("no single step after write");
  a_range_abort: assert property (accept && !chOk[grantCh] |=> abortPulse && !memReq) // RULE9
    else $error("out-of-window transfer not aborted");
  a_wb_ack_once: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
endmodule : dca_top
`default_nettype wire

// >>> dca_mem_model.sv
// Purpose: memory side model that answers the dma memory port
// Assumes: one access at a time, held until memAck
// Notes:   read data is address based and toggles while idle
`timescale 1ns/10ps
`default_nettype none
module dca_mem_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        memReq,
  input  wire logic [1:0]  lat,
  input  wire logic [15:0] memAddr,
  output logic             memAck,
  output logic      [15:0] memRdata
);
  logic [1:0] cnt;
  always_ff @(posedge clk) begin
    cnt      <= (srst || !memReq || memAck) ? 2'h0 : cnt + 2'h1;
    memAck   <= !srst && memReq && !memAck && cnt == lat;
    memRdata <= srst ? 16'h0 : (memReq && cnt == lat) ? memAddr ^ 16'h5a5a : ~memRdata;
  end
endmodule : dca_mem_model
`default_nettype wire

// >>> test_dma_channel_arbiter_setup.sv
// Purpose: self-checking bench of the dma controller
// Assumes: registers over classic wishbone, memory side modelled
// Notes:   grant order is predicted by pick
`timescale 1ns/10ps
`default_nettype none
module test_dma_channel_arbiter_setup;
  logic        clk = 0, srst = 1, cycI = 0, stbI = 0, weI = 0, ackO, memReq, memWe, memByte, memAck;
  logic [7:0]  adrI = 0;
  logic [3:0]  selI = 0, trig = 0;
  logic [31:0] datI = 0, datO;
  logic [15:0] memAddr, memWdata, memRdata, rdAddr, rdv;
  logic [1:0]  lat = 0, lastCh = 2'h3, got[$], expq[$];
  int          seed = 54636, numErrors = 0, numChecks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  dca_top u_dut (.clk(clk), .srst(srst), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
    .sel_i(selI), .dat_i(datI), .dat_o(datO), .ack_o(ackO), .trig(trig), .memReq(memReq), .memWe(memWe),
    .memByte(memByte), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
  dca_mem_model u_mem (.clk(clk), .srst(srst), .memReq(memReq), .lat(lat), .memAddr(memAddr),
    .memAck(memAck), .memRdata(memRdata));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    numChecks++;
    if (g !== e) begin
      numErrors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    {cycI, stbI, weI, adrI, selI, datI} <= {2'b11, w, a, 4'h3, 16'h0, d};
    do @(posedge clk); while (ackO !== 1'b1);
    rdv = datO[15:0];
    {cycI, stbI} <= 2'b00;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0);
    chk(rdv, e);
  endtask : rdchk
  // next winner: round robin after last, or fixed lowest skipping last
  function automatic logic [1:0] pick(input logic rr, input logic [1:0] last, input logic [3:0] p);
    logic [1:0] c;
    for (int i = 1; i < 5; i++) begin
      c = rr ? 2'(last + 2'(i)) : 2'(i - 1);
      if (p[c] && (rr || c != last || p == (4'h1 << last))) return c;
    end
    return last;
  endfunction : pick
  // enable channels, trigger at once, compare grant order
  task automatic burst(input logic rr, input logic live, input logic [3:0] en, input logic [3:0] m);
    logic [3:0] p;
    logic [1:0] c;
    p = live ? en & m : 4'h0;
    got.delete();
    expq.delete();
    while (p != 4'h0) begin
      c = pick(rr, lastCh, p);
      expq.push_back(c);
      p[c] = 1'b0;
      lastCh = c;
    end
    lat <= 2'($random(seed));
    for (int i = 0; i < 4; i++) if (en[i]) wb(1'b1, 8'(32 * i + 32), i == 3 ? 16'h3 : 16'h1);
    @(posedge clk) trig <= m;
    @(posedge clk) trig <= 4'h0;
    for (int n = 0; n < 200 && got.size() < expq.size(); n++) @(posedge clk);
    repeat (30) @(posedge clk);
    chk(16'(got.size()), 16'(expq.size()));
    foreach (expq[i]) chk(16'(got[i]), 16'(expq[i]));
  endtask : burst
  // memory port monitor and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      numErrors++;
      print_verdict();
    end
    if (memReq === 1'b1 && memAck === 1'b1 && memWe === 1'b0) rdAddr = memAddr;
    if (memReq === 1'b1 && memAck === 1'b1 && memWe === 1'b1) begin
      got.push_back(memAddr[5:4]);
      chk(16'(memAddr[5:4]), 16'(rdAddr[9:8]));
      chk(16'(memByte), 16'(rdAddr[9:8] == 2'h3));
      chk(memWdata, (rdAddr ^ 16'h5a5a) & (rdAddr[9:8] == 2'h3 ? 16'h00ff : 16'hffff));
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rdchk(8'h00, 16'h0000);
    rdchk(8'h04, 16'hffff);
    rdchk(8'h08, 16'h0000);
    rdchk(8'h1c, 16'h0000);
    wb(1'b1, 8'h00, 16'h1);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'(32 * i + 40), 16'h1000 | 16'(i << 8) | (16'($random(seed)) & 16'h00fe));
      wb(1'b1, 8'(32 * i + 44), 16'h2000 | 16'(i << 4));
      wb(1'b1, 8'(32 * i + 48), 16'h1);
    end
    burst(1'b0, 1'b1, 4'hf, 4'hf);
    wb(1'b1, 8'h00, 16'h3);
    burst(1'b1, 1'b1, 4'h2, 4'h2);
    burst(1'b1, 1'b1, 4'hf, 4'hf);
    wb(1'b1, 8'h00, 16'h1);
    burst(1'b0, 1'b1, 4'h5, 4'hf);
    burst(1'b0, 1'b1, 4'hc, 4'hc);
    // repeated mode, fixed source, two words on one trigger
    wb(1'b1, 8'h30, 16'h2);
    wb(1'b1, 8'h20, 16'h29);
    got.delete();
    @(posedge clk) trig <= 4'h1;
    @(posedge clk) trig <= 4'h0;
    repeat (80) @(posedge clk);
    chk(16'(got.size()), 16'h0002);
    rdchk(8'h2c, 16'h2004);
    rdchk(8'h30, 16'h0000);
    rdchk(8'h20, 16'h0028);
    wb(1'b1, 8'h08, 16'h1400);
    burst(1'b0, 1'b0, 4'h1, 4'h1);
    rdchk(8'h24, 16'h0003);
    wb(1'b1, 8'h08, 16'h0000);
    wb(1'b1, 8'h00, 16'h0);
    burst(1'b0, 1'b0, 4'hf, 4'hf);
    wb(1'b1, 8'h10, 16'h2);
    rdchk(8'h40, 16'h0000);
    rdchk(8'h6c, 16'h2020);
    print_verdict();
  end
endmodule : test_dma_channel_arbiter_setup
`default_nettype wire
